// >>> dv/sdc_mod_model.sv
// Modulator model: one-bit stream at full positive or full negative scale
// Assumes mod_clk stands still while the converter is off
`timescale 1ns/1ns
module sdc_mod_model (
  input  wire logic mod_clk,
  input  wire logic level,
  output logic      mod_data
);
  initial mod_data = 1'b0;
  always @(posedge mod_clk) mod_data <= level;
endmodule : sdc_mod_model

// >>> dv/sdc_props.sv
// Checker: port-level timing of the converter control top
// Assumes binding to sdc_top; software settings are tracked from APB writes
`timescale 1ns/1ns
module sdc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        mod_clk,
  input wire logic        converter_power,
  input wire logic        converter_irq
);
  logic       wr;
  logic       rd;
  logic [7:0] ctl_ff;
  logic [4:0] div_ff;
  logic [1:0] ien_ff;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h00;
      div_ff <= 5'h00;
      ien_ff <= 2'h0;
    end else begin
      if (wr && paddr == sdc_pkg::ADDR_CTRL_STATUS) ctl_ff <= pwdata[7:0] & 8'h2c;
      if (wr && paddr == sdc_pkg::ADDR_CLK_DIV) div_ff <= pwdata[4:0];
      if (wr && paddr == sdc_pkg::ADDR_IRQ_CFG) ien_ff <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_on; wr && paddr == sdc_pkg::ADDR_CTRL_STATUS |=> converter_power == $past(pwdata[2]); endproperty
  a_on: assert property (p_on) else $error("power does not follow enable bit");
  property p_off; !converter_power [*2] |-> !mod_clk; endproperty
  a_off: assert property (p_off) else $error("modulator clock runs while off");
  property p_ctl; rd && paddr == sdc_pkg::ADDR_CTRL_STATUS |-> (prdata & 32'hffffffef) == {24'h0, ctl_ff}; endproperty
  a_ctl: assert property (p_ctl) else $error("control read wrong");
  property p_div; rd && paddr == sdc_pkg::ADDR_CLK_DIV |-> prdata == {27'h0, div_ff}; endproperty
  a_div: assert property (p_div) else $error("divider read wrong");
  property p_irq; ien_ff != 2'h3 |-> !converter_irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");
  property p_byp; @(negedge pclk) (div_ff == 5'h1f && converter_power) [*3] |-> mod_clk; endproperty
  a_byp: assert property (p_byp) else $error("bypass clock not passed through");
  property p_hold; ctl_ff[5] && !converter_irq && !wr |=> !converter_irq; endproperty
  a_hold: assert property (p_hold) else $error("interrupt under hold");
  property p_keep; $fell(converter_irq) |-> $past(wr); endproperty
  a_keep: assert property (p_keep) else $error("request dropped by hardware");
endmodule : sdc_props
bind sdc_top sdc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .mod_clk(mod_clk),
  .converter_power(converter_power), .converter_irq(converter_irq));

// >>> dv/tb_top.sv
// Testbench: APB master driving the converter control top
// Assumes the modulator model on the far side and a 250 MHz pclk
`timescale 1ns/1ns
module tb_top;
  localparam logic [11:0] CTL = sdc_pkg::ADDR_CTRL_STATUS;
  localparam logic [11:0] DIV = sdc_pkg::ADDR_CLK_DIV;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mod_data, mod_clk, level, e;
  logic        converter_power, converter_irq;
  logic [31:0] prdata, pwdata, r;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  int          num_errors, n_tests;
  sdc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_data(mod_data),
    .mod_clk(mod_clk), .converter_power(converter_power), .converter_irq(converter_irq));
  sdc_mod_model u_mod (.mod_clk(mod_clk), .level(level), .mod_data(mod_data));
  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done;
    r = 32'h0;
    for (int i = 0; i < 2000 && r[4] !== 1'b1; i++) apb(1'b0, CTL, 8'h00);
    chk(r[4], 1'b1);
    apb(1'b1, CTL, 8'h04);
  endtask : wait_done
  task automatic rd_res(input logic [23:0] exp);
    logic [23:0] v;
    apb(1'b1, CTL, 8'h24);
    apb(1'b0, sdc_pkg::ADDR_RES_HIGH, 8'h00);
    v[23:16] = r[7:0];
    apb(1'b0, sdc_pkg::ADDR_RES_MID, 8'h00);
    v[15:8] = r[7:0];
    apb(1'b0, sdc_pkg::ADDR_RES_LOW, 8'h00);
    v[7:0] = r[7:0];
    chk({8'h00, v}, {8'h00, exp});
    apb(1'b1, CTL, 8'h04);
  endtask : rd_res
  task automatic settle(input logic [23:0] exp);
    repeat (4) wait_done;
    rd_res(exp);
  endtask : settle
  task automatic meas(input logic [7:0] code, input int exp);
    time t0;
    apb(1'b1, DIV, code);
    repeat (2) @(posedge mod_clk);
    t0 = $time;
    @(posedge mod_clk);
    chk(32'(($time - t0) / 4), exp);
  endtask : meas
  task automatic t_regs;
    apb(1'b0, CTL, 8'h00);
    chk(r, 32'h0);
    apb(1'b0, DIV, 8'h00);
    chk(r, 32'h0);
    apb(1'b1, CTL, 8'he3);
    apb(1'b0, CTL, 8'h00);
    chk(r, 32'h20);
    apb(1'b1, CTL, 8'h00);
    apb(1'b1, DIV, 8'hff);
    apb(1'b0, DIV, 8'h00);
    chk(r, 32'h1f);
    apb(1'b0, 12'h020, 8'h00);
    chk({r[30:0], e}, 32'h1);
  endtask : t_regs
  task automatic t_start;
    apb(1'b1, sdc_pkg::ADDR_RATE_CFG, 8'h08);
    apb(1'b1, sdc_pkg::ADDR_IRQ_CFG, 8'h03);
    apb(1'b1, CTL, 8'h04);
    apb(1'b1, CTL, 8'h0c);
    apb(1'b1, CTL, 8'h04);
    #1 chk(converter_power, 1'b1);
    settle(24'h7fffff);
    #1 chk(converter_irq, 1'b1);
    apb(1'b1, sdc_pkg::ADDR_IRQ_CFG, 8'h01);
    #1 chk(converter_irq, 1'b0);
    apb(1'b1, sdc_pkg::ADDR_IRQ_CFG, 8'h03);
    apb(1'b1, sdc_pkg::ADDR_IRQ_STATUS, 8'h01);
    #1 chk(converter_irq, 1'b0);
  endtask : t_start
  task automatic t_hold;
    apb(1'b1, CTL, 8'h24);
    apb(1'b1, sdc_pkg::ADDR_IRQ_STATUS, 8'h01);
    level <= 1'b0;
    repeat (1500) @(posedge pclk);
    apb(1'b0, CTL, 8'h00);
    chk(r, 32'h24);
    chk(converter_irq, 1'b0);
    rd_res(24'h7fffff);
    settle(24'h800000);
  endtask : t_hold
  task automatic t_div;
    meas(8'h00, 2);
    meas(8'h02, 6);
    meas(8'h1e, 62);
    meas(8'h1f, 1);
  endtask : t_div
  task automatic t_stop;
    apb(1'b1, CTL, 8'h0c);
    repeat (1500) @(posedge pclk);
    apb(1'b0, CTL, 8'h00);
    chk(r, 32'h0c);
    apb(1'b1, CTL, 8'h04);
    wait_done;
    apb(1'b1, CTL, 8'h00);
    #1 chk(converter_power, 1'b0);
    repeat (1500) @(posedge pclk);
    apb(1'b0, CTL, 8'h00);
    chk(r, 32'h0);
  endtask : t_stop
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    level = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_start;
    t_hold;
    t_div;
    t_stop;
    stop_test;
  end
endmodule : tb_top

// >>> rtl/sdc_decimator.sv
// Decimation filter: SINC2/SINC3 of a 1-bit modulator stream, saturated to 24 bits
// Assumes run low holds it in reset; mod_tick marks each modulator sample
`timescale 1ns/1ns
module sdc_decimator (
  input  wire logic pclk,
  input  wire logic presetn,
  sdc_mod_if.filt   fi
);
  logic [sdc_pkg::ACC_W-1:0] i1_ff, i2_ff, i3_ff, nxt_i1, nxt_i2, nxt_i3;
  logic [sdc_pkg::ACC_W-1:0] c1_ff, c2_ff, c3_ff, nxt_c1, nxt_c2, nxt_c3;
  logic [15:0] cnt_ff, nxt_cnt;
  logic        vld_ff, nxt_vld;
  logic [23:0] res_ff, nxt_res;
  logic [15:0] osr;
  logic [5:0]  shift;
  logic [sdc_pkg::ACC_W-1:0] d1, d2, d3, val, mid;
  logic signed [sdc_pkg::ACC_W-1:0] sval, scaled;

  always_comb begin
    osr     = 16'h8000 >> fi.osr_code;
    shift   = fi.third_order ? 6'(4'hf - fi.osr_code) * 6'h3 : 6'(4'hf - fi.osr_code) * 6'h2;
    nxt_i1  = i1_ff;
    nxt_i2  = i2_ff;
    nxt_i3  = i3_ff;
    nxt_c1  = c1_ff;
    nxt_c2  = c2_ff;
    nxt_c3  = c3_ff;
    nxt_cnt = cnt_ff;
    nxt_vld = 1'b0;
    nxt_res = res_ff;
    d1 = i3_ff - c1_ff;
    d2 = d1 - c2_ff;
    d3 = d2 - c3_ff;
    val = fi.third_order ? d3 : d2;
    mid = 48'h1 << (shift - 6'h1);
    // Centre unipolar count, then scale full scale to 2^23
    sval = $signed(val - mid);
    scaled = (shift >= 6'd24) ? (sval >>> (shift - 6'd24)) : (sval <<< (6'd24 - shift));
    if (!fi.run) begin
      nxt_i1 = '0; nxt_i2 = '0; nxt_i3 = '0;
      nxt_c1 = '0; nxt_c2 = '0; nxt_c3 = '0;
      nxt_cnt = '0;
    end else if (fi.mod_tick) begin
      nxt_i1 = i1_ff + {47'h0, fi.mod_bit};
      nxt_i2 = i2_ff + i1_ff;
      nxt_i3 = fi.third_order ? i3_ff + i2_ff : i2_ff;
      if (cnt_ff == osr - 16'h1) begin
        nxt_cnt = '0;
        nxt_c1 = i3_ff;
        nxt_c2 = d1;
        nxt_c3 = d2;
        nxt_vld = 1'b1;
        // Clamp to signed 24-bit range
        if (scaled > 48'sd8388607)
          nxt_res = sdc_pkg::RES_MAX;
        else if (scaled < -48'sd8388608)
          nxt_res = sdc_pkg::RES_MIN;
        else
          nxt_res = scaled[23:0];
      end else begin
        nxt_cnt = cnt_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i1_ff <= '0; i2_ff <= '0; i3_ff <= '0;
      c1_ff <= '0; c2_ff <= '0; c3_ff <= '0;
      cnt_ff <= '0; vld_ff <= 1'b0; res_ff <= '0;
    end else begin
      i1_ff <= nxt_i1; i2_ff <= nxt_i2; i3_ff <= nxt_i3;
      c1_ff <= nxt_c1; c2_ff <= nxt_c2; c3_ff <= nxt_c3;
      cnt_ff <= nxt_cnt; vld_ff <= nxt_vld; res_ff <= nxt_res;
    end
  end

  assign fi.result_valid = vld_ff;
  assign fi.result       = res_ff;
endmodule : sdc_decimator

// >>> rtl/sdc_mod_if.sv
// Interface: signals between control top and decimation filter
// Assumes both ends on pclk
`timescale 1ns/1ns
interface sdc_mod_if;
  logic        run;
  logic        mod_tick;
  logic        mod_bit;
  logic        third_order;
  logic [3:0]  osr_code;
  logic        result_valid;
  logic [23:0] result;
  modport ctrl (output run, output mod_tick, output mod_bit, output third_order, output osr_code,
                input result_valid, input result);
  modport filt (input run, input mod_tick, input mod_bit, input third_order, input osr_code,
                output result_valid, output result);
endinterface : sdc_mod_if

// >>> rtl/sdc_pkg.sv
// Package: register map, field positions, reset values and counts of the converter control block
// Assumes a 32-bit APB bus and a single pclk domain
package sdc_pkg;
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CLK_DIV     = 12'h004;
  localparam logic [11:0] ADDR_RATE_CFG    = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CFG     = 12'h00c;
  localparam logic [11:0] ADDR_RES_LOW     = 12'h010;
  localparam logic [11:0] ADDR_RES_MID     = 12'h014;
  localparam logic [11:0] ADDR_RES_HIGH    = 12'h018;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h01c;

  localparam int BIT_HOLD    = 5;
  localparam int BIT_DONE    = 4;
  localparam int BIT_FRST    = 3;
  localparam int BIT_ON      = 2;
  localparam int BIT_ORDER   = 7;
  localparam int BIT_GIE     = 0;
  localparam int BIT_CIE     = 1;

  localparam logic [7:0] CTRL_MASK   = 8'h3c;
  localparam logic [7:0] DIV_MASK    = 8'h1f;
  localparam logic [7:0] RATE_MASK   = 8'hbf;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] DIV_RST     = 8'h00;
  localparam logic [7:0] RATE_RST    = 8'h00;
  localparam logic [4:0] DIV_BYPASS  = 5'h1f;
  localparam logic [3:0] OSR_MAX_CODE = 4'h8;
  localparam logic [23:0] RES_MAX    = 24'h7fffff;
  localparam logic [23:0] RES_MIN    = 24'h800000;
  localparam int ACC_W = 48;
endpackage : sdc_pkg

// >>> rtl/sdc_top.sv
// Top: APB register file, modulator clock divider, start sequencing, result hold
// Assumes mod_data is a 1-bit modulator output, asynchronous to pclk
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
// Functional notes
// - Hold set freezes result registers; later results ignored until hold cleared
// - Under hold the converter runs but done flag and request stay unchanged
// - Done flag is 0 during conversion, 1 after; only software clears it
// - Filter-reset bit high holds filter in reset, discards result, blocks start
// - Low-high-low on filter-reset bit starts conversions
// - Converter-enable low switches converter off; high enables it
// - Divider codes 0..30 give sysclk/2/(n+1); code 31 gives sysclk
// - Each conversion end without hold sets done flag and interrupt request flag
// - Without hold every new result overwrites result registers
// - Interrupt out only when global and converter interrupt enables set
// - Result is 24-bit two's complement, MSB is sign
// - Result saturates at 8388607 and -8388608
// - Largest code 0x7fffff, smallest 0x800000, LSB is reference span over 8388608
// - Unimplemented control bits read as zero
// - Hold enable is bit 5 of control register, reset zero
// - Four-bit oversampling code 0 gives 32768, halving to code 8 giving 128
// - Filter-order bit 0 selects third order, 1 selects second order
module sdc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod_data,
  output logic             mod_clk,
  output logic             converter_power,
  output logic             converter_irq
);
  sdc_mod_if mi ();

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } sdc_state_e;

  sdc_state_e  st_ff, nxt_st;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [7:0]  div_ff, nxt_div;
  logic [7:0]  rate_ff, nxt_rate;
  logic [1:0]  ien_ff, nxt_ien;
  logic        req_ff, nxt_req;
  logic [23:0] res_ff, nxt_res;
  logic [4:0]  dcnt_ff, nxt_dcnt;
  logic        half_ff, nxt_half;
  logic        mclk_ff, nxt_mclk;
  logic        tick_ff, nxt_tick;
  logic        sync1_ff, sync2_ff;
  logic        wr_en, rd_en, hit, byp;
  logic [7:0]  wbyte;
  logic [31:0] rdata;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == sdc_pkg::ADDR_CTRL_STATUS) || (a == sdc_pkg::ADDR_CLK_DIV) ||
              (a == sdc_pkg::ADDR_RATE_CFG) || (a == sdc_pkg::ADDR_IRQ_CFG) ||
              (a == sdc_pkg::ADDR_RES_LOW) || (a == sdc_pkg::ADDR_RES_MID) ||
              (a == sdc_pkg::ADDR_RES_HIGH) || (a == sdc_pkg::ADDR_IRQ_STATUS);
  endfunction : addr_ok

  // Bus access strobes, zero wait state
  assign pready  = 1'b1;
  assign hit     = addr_ok(paddr);
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit && pstrb[0];
  assign rd_en   = psel && penable && !pwrite;
  assign wbyte   = pwdata[7:0];

  // Modulator input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= mod_data;
      sync2_ff <= sync1_ff;
    end
  end

  // Modulator clock divider
  always_comb begin
    nxt_dcnt = dcnt_ff;
    nxt_half = half_ff;
    nxt_mclk = mclk_ff;
    nxt_tick = 1'b0;
    if (!ctrl_ff[sdc_pkg::BIT_ON]) begin
      nxt_dcnt = '0;
      nxt_half = 1'b0;
      nxt_mclk = 1'b0;
    end else if (div_ff[4:0] == sdc_pkg::DIV_BYPASS) begin
      nxt_dcnt = '0;
      nxt_half = 1'b0;
      nxt_mclk = 1'b0;
      nxt_tick = 1'b1;
    end else if (dcnt_ff >= div_ff[4:0]) begin
      nxt_dcnt = '0;
      nxt_half = ~half_ff;
      nxt_mclk = ~mclk_ff;
      nxt_tick = ~mclk_ff;
    end else begin
      nxt_dcnt = dcnt_ff + 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_ff <= '0;
      half_ff <= 1'b0;
      mclk_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      dcnt_ff <= nxt_dcnt;
      half_ff <= nxt_half;
      mclk_ff <= nxt_mclk;
      tick_ff <= nxt_tick;
    end
  end

  // Start sequencing
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_OFF: begin
        if (ctrl_ff[sdc_pkg::BIT_ON] && ctrl_ff[sdc_pkg::BIT_FRST])
          nxt_st = ST_ARMED;
      end
      ST_ARMED: begin
        if (!ctrl_ff[sdc_pkg::BIT_ON])
          nxt_st = ST_OFF;
        else if (!ctrl_ff[sdc_pkg::BIT_FRST])
          nxt_st = ST_RUN;
      end
      ST_RUN: begin
        if (!ctrl_ff[sdc_pkg::BIT_ON])
          nxt_st = ST_OFF;
        else if (ctrl_ff[sdc_pkg::BIT_FRST])
          nxt_st = ST_ARMED;
      end
      default: nxt_st = ST_OFF;
    endcase
  end

  assign mi.run         = (st_ff == ST_RUN) && !ctrl_ff[sdc_pkg::BIT_FRST];
  assign mi.mod_tick    = tick_ff;
  assign mi.mod_bit     = sync2_ff;
  assign mi.third_order = !rate_ff[sdc_pkg::BIT_ORDER];
  assign mi.osr_code    = (rate_ff[3:0] > sdc_pkg::OSR_MAX_CODE) ? sdc_pkg::OSR_MAX_CODE : rate_ff[3:0];

  // Registers, flags and result
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_div  = div_ff;
    nxt_rate = rate_ff;
    nxt_ien  = ien_ff;
    nxt_req  = req_ff;
    nxt_res  = res_ff;
    if (wr_en) begin
      unique case (paddr)
        sdc_pkg::ADDR_CTRL_STATUS: nxt_ctrl = wbyte & sdc_pkg::CTRL_MASK;
        sdc_pkg::ADDR_CLK_DIV:     nxt_div  = wbyte & sdc_pkg::DIV_MASK;
        sdc_pkg::ADDR_RATE_CFG:    nxt_rate = wbyte & sdc_pkg::RATE_MASK;
        sdc_pkg::ADDR_IRQ_CFG:     nxt_ien  = wbyte[1:0];
        sdc_pkg::ADDR_IRQ_STATUS:  nxt_req  = req_ff & !wbyte[0];
        default: ;
      endcase
    end
    // Conversion end sets flags; set wins over a same-cycle clear
    if (mi.result_valid && mi.run && !ctrl_ff[sdc_pkg::BIT_HOLD]) begin
      nxt_res = mi.result;
      nxt_ctrl[sdc_pkg::BIT_DONE] = 1'b1;
      nxt_req = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff        <= ST_OFF;
      ctrl_ff      <= sdc_pkg::CTRL_RST;
      div_ff       <= sdc_pkg::DIV_RST;
      rate_ff      <= sdc_pkg::RATE_RST;
      ien_ff       <= 2'h0;
      req_ff       <= 1'b0;
      res_ff       <= '0;
    end else begin
      st_ff        <= nxt_st;
      ctrl_ff      <= nxt_ctrl;
      div_ff       <= nxt_div;
      rate_ff      <= nxt_rate;
      ien_ff       <= nxt_ien;
      req_ff       <= nxt_req;
      res_ff       <= nxt_res;
    end
  end

  // Read mux
  always_comb begin
    rdata = 32'h0;
    unique case (paddr)
      sdc_pkg::ADDR_CTRL_STATUS: rdata = {24'h0, ctrl_ff};
      sdc_pkg::ADDR_CLK_DIV:     rdata = {24'h0, div_ff};
      sdc_pkg::ADDR_RATE_CFG:    rdata = {24'h0, rate_ff};
      sdc_pkg::ADDR_IRQ_CFG:     rdata = {30'h0, ien_ff};
      sdc_pkg::ADDR_RES_LOW:     rdata = {24'h0, res_ff[7:0]};
      sdc_pkg::ADDR_RES_MID:     rdata = {24'h0, res_ff[15:8]};
      sdc_pkg::ADDR_RES_HIGH:    rdata = {24'h0, res_ff[23:16]};
      sdc_pkg::ADDR_IRQ_STATUS:  rdata = {31'h0, req_ff};
      default:                   rdata = 32'h0;
    endcase
  end

  assign prdata          = rd_en ? rdata : 32'h0;
  // Bypass passes the system clock itself
  assign byp             = ctrl_ff[sdc_pkg::BIT_ON] && (div_ff[4:0] == sdc_pkg::DIV_BYPASS);
  assign mod_clk         = byp ? pclk : mclk_ff;
  assign converter_power = ctrl_ff[sdc_pkg::BIT_ON];
  assign converter_irq   = req_ff && ien_ff[sdc_pkg::BIT_GIE] && ien_ff[sdc_pkg::BIT_CIE];

  sdc_decimator u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (mi)
  );
endmodule : sdc_top
